// ---- bench/tsrp_core_test.sv ----
// Self-checking bench for the temperature readout block
`timescale 1ns/1ps
`default_nettype none
module tsrp_core_test;
   logic clk = 1'b0, resetn = 1'b0, done_p = 1'b0, busy = 1'b0;
   logic [15:0] result = 16'h0000;
   wire sel_n, sclk, sio_i, sio_o, oe_n, run, single, pdown, valid, dflag;
   wire [1:0] res;
   int fails = 0, n_tests = 0, nsing = 0;
   logic [15:0] raw_m = 16'h0000;
   logic [1:0] res_m = 2'h0;
   logic tog_m = 1'b0, since_m = 1'b0, pend_m = 1'b0, vld_m = 1'b0, done_m = 1'b0;
   always #4 clk = ~clk;
   tsrp_core tsrp_core_i (.clk_i(clk), .resetn_i(resetn), .ce_i(1'b1),
      .sel_n_i(sel_n), .serial_shift_clock_i(sclk), .sio_i(sio_i), .sio_o(sio_o),
      .sio_oe_n_o(oe_n), .conv_done_i(done_p), .conv_result_i(result),
      .conv_busy_i(busy), .conv_run_o(run), .conv_single_o(single),
      .resolution_o(res), .power_down_o(pdown), .data_valid_o(valid),
      .conversion_done_flag_o(dflag));
   tsrp_host_model tsrp_host_model_i (.sio_o(sio_o), .sio_oe_n_o(oe_n),
      .sel_n(sel_n), .sclk(sclk), .sio_i(sio_i));
   // Count single-start pulses to catch starts that should be ignored
   always @(posedge clk)
      if (single === 1'b1) nsing++;
   task chk(input logic [15:0] s, input logic [15:0] e, input string n);
      n_tests++;
      if (s !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   // Expected word; masking follows the resolution at frame start
   function logic [15:0] texp();
      if (pend_m) return 16'h8000;
      case (res_m)
         2'h0: return {raw_m[15:3], 2'b00, tog_m};
         2'h1: return {raw_m[15:2], 1'b0, tog_m};
         2'h2: return {raw_m[15:1], tog_m};
         default: return raw_m;
      endcase
   endfunction
   // Toggle model: flips at a frame start after a finished conversion
   task frm(output logic [15:0] e);
      if (since_m && res_m != 2'h3) tog_m = ~tog_m;
      since_m = 1'b0;
      e = texp();
   endtask
   task conv(input logic [15:0] r);
      @(negedge clk) result = r;
      done_p = 1'b1;
      @(negedge clk) done_p = 1'b0;
      raw_m = r;
      since_m = 1'b1;
      pend_m = 1'b0;
      vld_m = 1'b1;
      done_m = 1'b1;
   endtask
   task rd(input logic [7:0] c, input logic [15:0] dx);
      logic [15:0] e, t, d;
      logic [7:0] b;
      frm(e);
      tsrp_host_model_i.open();
      tsrp_host_model_i.word(16'h0000, 1'b0, t);
      if (vld_m) chk(t, e, "temperature");
      tsrp_host_model_i.cmd(c, 1'b1, b);
      tsrp_host_model_i.word(16'h0000, 1'b0, d);
      tsrp_host_model_i.close();
      chk(d, dx, "register");
      if (c == 8'h81) done_m = 1'b0;
   endtask
   task wr(input logic [7:0] c, input logic [15:0] w);
      logic [15:0] e, t, d;
      logic [7:0] b;
      frm(e);
      tsrp_host_model_i.open();
      tsrp_host_model_i.word(16'h0000, 1'b0, t);
      if (vld_m) chk(t, e, "temperature");
      tsrp_host_model_i.cmd(c, 1'b1, b);
      tsrp_host_model_i.word(w, 1'b1, d);
      tsrp_host_model_i.close();
   endtask
   task t_regs();
      static logic [7:0] c [10] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'h80, 8'h84, 8'h85, 8'h86,
         8'h8a, 8'hc1};
      static logic [15:0] v [10] = '{16'h0000, 16'h4880, 16'h4600, 16'h5a00, 16'h0, 16'h0,
         16'h0, 16'h0, 16'h0, 16'h0};
      logic [7:0] b;
      logic [15:0] e;
      chk({10'h000, valid, dflag, pdown, run, res}, 16'h0004, "reset outputs");
      for (int i = 0; i < 10; i++) rd(c[i], v[i]);
      wr(8'h04, 16'hffff);
      wr(8'h0a, 16'hffff);
      wr(8'h07, 16'hffff);
      rd(8'h82, 16'h4880);
      rd(8'h87, 16'h5a00);
      wr(8'h02, 16'h1234);
      rd(8'h82, 16'h1220);
      frm(e);
      tsrp_host_model_i.open();
      tsrp_host_model_i.word(16'h0000, 1'b0, v[0]);
      tsrp_host_model_i.cmd(8'h02, 1'b1, b);
      tsrp_host_model_i.cmd(8'hab, 1'b1, b);
      tsrp_host_model_i.close();
      rd(8'h82, 16'hab20);
      $display("test regs done");
   endtask
   task t_format();
      conv(16'h4b26);
      chk({14'h0000, valid, dflag}, 16'h0003, "valid and done");
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h01, {10'h000, i[1:0], 4'h0});
         res_m = i[1:0];
         chk({14'h0, res}, i[15:0], "resolution");
         rd(8'h81, {7'h00, done_m, 2'b00, res_m, 4'h0});
      end
      wr(8'h01, 16'h0006);
      res_m = 2'h0;
      rd(8'h81, 16'h0006);
      $display("test format done");
   endtask
   task t_pdown();
      logic [15:0] e;
      logic [7:0] b;
      busy = 1'b1;
      wr(8'h01, 16'h8000);
      chk({14'h0, run, pdown}, 16'h0, "run while busy");
      conv(16'h1238);
      @(negedge clk) busy = 1'b0;
      repeat (4) @(negedge clk);
      chk({15'h0, pdown}, 16'h1, "power-down");
      rd(8'h81, 16'h8100);
      wr(8'h01, 16'hc000);
      pend_m = 1'b1;
      chk(nsing[15:0], 16'h0001, "single starts");
      rd(8'h81, 16'h8000);
      conv(16'h0c80);
      rd(8'h81, 16'h8100);
      frm(e);
      tsrp_host_model_i.open();
      tsrp_host_model_i.cmd(8'h00, 1'b0, b);
      tsrp_host_model_i.close();
      chk({8'h00, b}, {8'h00, e[15:8]}, "early byte");
      wr(8'h01, 16'h0000);
      chk({14'h0, run, pdown}, 16'h2, "resume");
      wr(8'h01, 16'h4000);
      chk(nsing[15:0], 16'h0001, "single ignored");
      $display("test power-down done");
   endtask
   task end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      #600_000;
      fails++;
      end_sim();
   end
   initial
   begin
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      repeat (8) @(negedge clk);
      t_regs();
      t_format();
      t_pdown();
      end_sim();
   end
endmodule
`default_nettype wire

// ---- bench/tsrp_host_model.sv ----
// Serial master model: select, shift clock and the shared data line
`timescale 1ns/1ps
`default_nettype none
module tsrp_host_model
(
   input  wire logic sio_o,
   input  wire logic sio_oe_n_o,
   output var  logic sel_n,
   output var  logic sclk,
   output wire logic sio_i
);
   logic hb;
   // Device wins the wire while it drives; otherwise the host level
   assign sio_i = sio_oe_n_o ? hb : sio_o;
   initial
   begin
      sel_n = 1'b1;
      sclk  = 1'b0;
      hb    = 1'b0;
   end
   // One bit: data set while clock low, sampled at the rising edge
   task bitx(input logic b, input logic drv, output logic s);
   begin
      hb = drv ? b : ~sio_i; // Released line shows the inverse level
      #62.5 sclk = 1'b1;
      s = sio_i;
      #62.5 sclk = 1'b0;
   end
   endtask
   // Clock stands still outside frames
   task open();
      sel_n = 1'b0;
      #62.5;
   endtask
   task close();
      #62.5 sel_n = 1'b1;
      #300;
   endtask
   task cmd(input logic [7:0] c, input logic drv, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) bitx(c[i], drv, r[i]);
   endtask
   task word(input logic [15:0] w, input logic drv, output logic [15:0] r);
      for (int i = 15; i >= 0; i--) bitx(w[i], drv, r[i]);
   endtask
endmodule
`default_nettype wire

// ---- bench/tsrp_monitor.sv ----
// Checker for the readout block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module tsrp_monitor
(
   input wire logic       clk_i,
   input wire logic       resetn_i,
   input wire logic       sel_n_i,
   input wire logic       sio_oe_n_o,
   input wire logic       conv_done_i,
   input wire logic       conv_busy_i,
   input wire logic       conv_run_o,
   input wire logic       conv_single_o,
   input wire logic [1:0] resolution_o,
   input wire logic       power_down_o,
   input wire logic       data_valid_o,
   input wire logic       conversion_done_flag_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   // ----------------------------------------------------------------
   // Frame sequences: pin held long enough to pass the filter
   // ----------------------------------------------------------------
   sequence s_sel_fall;
      $fell(sel_n_i) ##1 (!sel_n_i) [*8];
   endsequence
   sequence s_sel_idle;
      sel_n_i [*8];
   endsequence
   property p_oe_start;
      s_sel_fall |-> !sio_oe_n_o;
   endproperty
   property p_oe_idle;
      s_sel_idle |=> sio_oe_n_o;
   endproperty
   property p_single_pd;
      conv_single_o |-> power_down_o;
   endproperty
   property p_single_one;
      conv_single_o |=> !conv_single_o;
   endproperty
   property p_valid_set;
      conv_done_i |=> data_valid_o;
   endproperty
   property p_valid_keep;
      data_valid_o |=> data_valid_o;
   endproperty
   property p_done_flag;
      conv_done_i |=> conversion_done_flag_o;
   endproperty
   property p_res_frame;
      $changed(resolution_o) |-> !sel_n_i;
   endproperty
   property p_pd_wait;
      $rose(power_down_o) |-> !$past(conv_busy_i);
   endproperty
   property p_pd_run;
      $rose(power_down_o) |-> !conv_run_o;
   endproperty
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_oe_start: assert property (p_oe_start)
      else $error("line not driven after select fell");
   a_oe_idle: assert property (p_oe_idle)
      else $error("line driven while deselected");
   a_single_pd: assert property (p_single_pd)
      else $error("single start outside power-down");
   a_single_one: assert property (p_single_one)
      else $error("single start longer than one cycle");
   a_valid_set: assert property (p_valid_set)
      else $error("valid not set by conversion");
   a_valid_keep: assert property (p_valid_keep)
      else $error("valid dropped");
   a_done_flag: assert property (p_done_flag)
      else $error("done flag not set by conversion");
   a_res_frame: assert property (p_res_frame)
      else $error("resolution changed outside a frame");
   a_pd_wait: assert property (p_pd_wait)
      else $error("power-down entered while busy");
   a_pd_run: assert property (p_pd_run)
      else $error("still running in power-down");
endmodule
bind tsrp_core tsrp_monitor tsrp_monitor_i (.clk_i(clk_i), .resetn_i(resetn_i),
   .sel_n_i(sel_n_i), .sio_oe_n_o(sio_oe_n_o), .conv_done_i(conv_done_i),
   .conv_busy_i(conv_busy_i), .conv_run_o(conv_run_o), .conv_single_o(conv_single_o),
   .resolution_o(resolution_o), .power_down_o(power_down_o),
   .data_valid_o(data_valid_o), .conversion_done_flag_o(conversion_done_flag_o));
`default_nettype wire

// ---- logic/tsrp_consts.vh ----
// Constants for the temperature result and pointer readout block
`ifndef TSRP_CONSTS_VH
`define TSRP_CONSTS_VH

// ----------------------------------------------------------------------
// Pointer decode (command byte)
// ----------------------------------------------------------------------
`define TSRP_CMD_RW_BIT      7
`define TSRP_PTR_CTRL        3'h1
`define TSRP_PTR_UPPER       3'h2
`define TSRP_PTR_LOWER       3'h3
`define TSRP_PTR_IDENT       3'h7
`define TSRP_CMD_RESET       8'h00

// ----------------------------------------------------------------------
// Control/status fields, positions within their byte
// ----------------------------------------------------------------------
`define TSRP_CS_PDOWN_BIT    7
`define TSRP_CS_SINGLE_BIT   6
`define TSRP_CS_RES_HI       5
`define TSRP_CS_RES_LO       4
`define TSRP_CS_RSV_HI       2
`define TSRP_CS_RSV_LO       1

// ----------------------------------------------------------------------
// Resolution codes and reset values
// ----------------------------------------------------------------------
`define TSRP_RES_13          2'h0
`define TSRP_RES_14          2'h1
`define TSRP_RES_15          2'h2
`define TSRP_RES_16          2'h3
`define TSRP_UPPER_RESET     16'h4880
`define TSRP_LOWER_RESET     16'h4600
`define TSRP_LIMIT_MASK      16'hffe0
`define TSRP_SINGLE_MARK     16'h8000
`define TSRP_ZERO_WORD       16'h0000

// ----------------------------------------------------------------------
// Serial framing counts
// ----------------------------------------------------------------------
`define TSRP_WORD_BITS       5'h10
`define TSRP_BYTE_LAST       5'h07
`define TSRP_WORD_LAST       5'h0f

`endif

// ---- logic/tsrp_core.v ----
// Serial temperature readout: result word, command pointer and register access
`timescale 1ns/1ps
`default_nettype none
`include "tsrp_consts.vh"

// What this block does
// - 14-bit: sign on top, toggle in bit zero, bit one forced zero.
// - 15-bit: sign on top, toggle in bit zero, magnitude between.
// - 16-bit: all sixteen bits are temperature, no toggle.
// - Result held as two's complement, 128 degrees down to 0.0078125.
// - Word shifted out MSB byte first, MSB first; host may stop early.
// - A running conversion finishes and updates the result before power-down.
// - Clearing power-down bit resumes continuous conversion.
// - All registers reachable in continuous and power-down modes.
// - In power-down the last result, continuous or single, stays readable.
// - Command bit seven says read or write for the next data phase.
// - Command bits six to three are zero; illegal pointer reads all zeros.
// - Pointer 1 control, 2 upper, 3 lower, 7 identity; others invalid.
// - Command pointer resets to zero, the temperature register.
// - Every transaction opens with the 16-bit temperature read.
// - Result invalid until the first conversion completes.
// - Resolution 13 to 16 bits comes from control bits five and four.
// - Bits unused at the chosen resolution read as zero.
// - Below 16 bits, bit zero flips per read if a conversion finished.
// - While a single conversion is pending the result reads 8000h.
// - Resolution code 0..3 selects 13, 14, 15, 16 bits.
// - Falling select starts a frame; first sixteen clocks shift temperature out.
// - Written data latches only in whole bytes.
// - Single request starts one conversion only while powered down.
module tsrp_core
#(
   parameter [15:0] ID_CODE = 16'h5a00   // Arbitrary identity value
)
(
   input  wire        clk_i,
   input  wire        resetn_i,
   input  wire        ce_i,
   input  wire        sel_n_i,
   input  wire        serial_shift_clock_i,
   input  wire        sio_i,
   output wire        sio_o,
   output wire        sio_oe_n_o,
   input  wire        conv_done_i,
   input  wire [15:0] conv_result_i,
   input  wire        conv_busy_i,
   output wire        conv_run_o,
   output wire        conv_single_o,
   output wire [1:0]  resolution_o,
   output wire        power_down_o,
   output wire        data_valid_o,
   output wire        conversion_done_flag_o
);

   // ----------------------------------------------------------------------
   // Serial phases
   // ----------------------------------------------------------------------
   localparam [1:0] PH_TEMP = 2'h0;
   localparam [1:0] PH_CMD  = 2'h1;
   localparam [1:0] PH_RD   = 2'h2;
   localparam [1:0] PH_WR   = 2'h3;

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------

   // Legal pointer: bits six to three zero and a mapped register select
   function ptr_ok;
      input [7:0] p;
      begin
         ptr_ok = 1'b0;
         if (p[6:3] == 4'h0)
         begin
            case (p[2:0])
               `TSRP_PTR_CTRL:  ptr_ok = 1'b1;
               `TSRP_PTR_UPPER: ptr_ok = 1'b1;
               `TSRP_PTR_LOWER: ptr_ok = 1'b1;
               `TSRP_PTR_IDENT: ptr_ok = 1'b1;
               default:         ptr_ok = 1'b0;
            endcase
         end
      end
   endfunction

   // Shape the raw result for the chosen resolution
   function [15:0] fmt_temp;
      input [15:0] raw;
      input [1:0]  res;
      input        tog;
      begin
         case (res)
            `TSRP_RES_13: fmt_temp = {raw[15:3], 2'b00, tog};
            `TSRP_RES_14: fmt_temp = {raw[15:2], 1'b0, tog};
            `TSRP_RES_15: fmt_temp = {raw[15:1], tog};
            default:      fmt_temp = raw;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   wire sel_n_s;
   wire sclk_s;
   wire sdi_s;

   tsrp_pin_sync #(.RST_VAL(1'b1)) u_sync_sel
   (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .ce_i     (ce_i),
      .pin_i    (sel_n_i),
      .level_o  (sel_n_s)
   );

   tsrp_pin_sync #(.RST_VAL(1'b0)) u_sync_sclk
   (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .ce_i     (ce_i),
      .pin_i    (serial_shift_clock_i),
      .level_o  (sclk_s)
   );

   tsrp_pin_sync #(.RST_VAL(1'b0)) u_sync_sdi
   (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .ce_i     (ce_i),
      .pin_i    (sio_i),
      .level_o  (sdi_s)
   );

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   reg        sel_n_q;
   reg        sclk_q;
   reg [1:0]  phase_q;
   reg [4:0]  cnt_q;
   reg [7:0]  in_q;
   reg [15:0] out_q;
   reg        oe_n_q;
   reg [7:0]  ptr_q;
   reg [15:0] temp_q;
   reg        valid_q;
   reg        new_q;
   reg        tog_q;
   reg        pend_q;
   reg        dav_q;
   reg        pdown_q;
   reg        shut_q;
   reg        single_q;
   reg [1:0]  res_q;
   reg [1:0]  rsv_q;
   reg [15:0] upper_q;
   reg [15:0] lower_q;

   // Edge finding on the filtered pins; clock edges only count inside a frame
   wire       sel_fall  = sel_n_q & ~sel_n_s;
   wire       sclk_rise = ~sclk_q & sclk_s & ~sel_n_s;
   wire       sclk_fall = sclk_q & ~sclk_s & ~sel_n_s;
   wire [7:0] byte_in   = {in_q[6:0], sdi_s};
   wire       tog_next  = tog_q ^ new_q;
   wire [15:0] ctrl_word = {pdown_q, 6'h00, dav_q, 2'b00, res_q, 1'b0, rsv_q, 1'b0};

   // Word presented at the opening of each frame
   wire [15:0] temp_word = pend_q ? `TSRP_SINGLE_MARK
                                  : fmt_temp(temp_q, res_q, tog_next);

   // ----------------------------------------------------------------------
   // Read data for a freshly received read command
   // ----------------------------------------------------------------------
   reg [15:0] rd_word;

   always @*
   begin
      rd_word = `TSRP_ZERO_WORD;
      if (ptr_ok(byte_in))
      begin
         case (byte_in[2:0])
            `TSRP_PTR_CTRL:  rd_word = ctrl_word;
            `TSRP_PTR_UPPER: rd_word = upper_q & `TSRP_LIMIT_MASK;
            `TSRP_PTR_LOWER: rd_word = lower_q & `TSRP_LIMIT_MASK;
            `TSRP_PTR_IDENT: rd_word = ID_CODE;
            default:         rd_word = `TSRP_ZERO_WORD;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Serial engine, register file and conversion bookkeeping
   // ----------------------------------------------------------------------

   // One process so that every flag has a single writer; the conversion
   // section sits last so a completion beats a clear in the same cycle
   always @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         sel_n_q  <= 1'b1;
         sclk_q   <= 1'b0;
         phase_q  <= PH_TEMP;
         cnt_q    <= 5'h00;
         in_q     <= 8'h00;
         out_q    <= 16'h0000;
         oe_n_q   <= 1'b1;
         ptr_q    <= `TSRP_CMD_RESET;
         temp_q   <= 16'h0000;
         valid_q  <= 1'b0;
         new_q    <= 1'b0;
         tog_q    <= 1'b0;
         pend_q   <= 1'b0;
         dav_q    <= 1'b0;
         pdown_q  <= 1'b0;
         shut_q   <= 1'b0;
         single_q <= 1'b0;
         res_q    <= `TSRP_RES_13;
         rsv_q    <= 2'b00;
         upper_q  <= `TSRP_UPPER_RESET;
         lower_q  <= `TSRP_LOWER_RESET;
      end
      else if (ce_i)
      begin
         sel_n_q  <= sel_n_s;
         sclk_q   <= sclk_s;
         single_q <= 1'b0;

         // Select high ends any phase and frees the data line
         if (sel_n_s)
         begin
            phase_q <= PH_TEMP;
            cnt_q   <= 5'h00;
            oe_n_q  <= 1'b1;
         end
         else if (sel_fall)
         begin
            // Each frame opens with the temperature word; this is its read
            phase_q <= PH_TEMP;
            cnt_q   <= 5'h00;
            out_q   <= temp_word;
            oe_n_q  <= 1'b0;
            if (!pend_q && res_q != `TSRP_RES_16)
               tog_q <= tog_next;
            new_q   <= 1'b0;
         end
         else
         begin
            // Bits move on the falling clock; the fall after a read command keeps bit 15
            if (sclk_fall && (phase_q == PH_TEMP || (phase_q == PH_RD && cnt_q != 5'h00)))
               out_q <= {out_q[14:0], 1'b0};
            if (sclk_rise)
            begin
               in_q  <= byte_in;
               cnt_q <= cnt_q + 5'h01;
               case (phase_q)
                  PH_TEMP:
                  begin
                     // Line turns round after the sixteenth bit
                     if (cnt_q == `TSRP_WORD_LAST)
                     begin
                        phase_q <= PH_CMD;
                        cnt_q   <= 5'h00;
                        oe_n_q  <= 1'b1;
                     end
                  end
                  PH_CMD:
                  begin
                     if (cnt_q == `TSRP_BYTE_LAST)
                     begin
                        ptr_q <= byte_in;
                        cnt_q <= 5'h00;
                        if (byte_in[`TSRP_CMD_RW_BIT])
                        begin
                           phase_q <= PH_RD;
                           out_q   <= rd_word;
                           oe_n_q  <= 1'b0;
                           // Reading the control word consumes the done flag
                           if (ptr_ok(byte_in) && byte_in[2:0] == `TSRP_PTR_CTRL)
                              dav_q <= 1'b0;
                        end
                        else
                           phase_q <= PH_WR;
                     end
                  end
                  PH_RD:
                  begin
                     if (cnt_q == `TSRP_WORD_LAST)
                     begin
                        phase_q <= PH_CMD;
                        cnt_q   <= 5'h00;
                        oe_n_q  <= 1'b1;
                     end
                  end
                  PH_WR:
                  begin
                     // Upper byte commits at bit eight, lower byte at sixteen
                     if (cnt_q == `TSRP_BYTE_LAST && ptr_ok(ptr_q))
                     begin
                        case (ptr_q[2:0])
                           `TSRP_PTR_CTRL:
                           begin
                              pdown_q <= byte_in[`TSRP_CS_PDOWN_BIT];
                              if (byte_in[`TSRP_CS_SINGLE_BIT] && shut_q)
                              begin
                                 single_q <= 1'b1;
                                 pend_q   <= 1'b1;
                                 dav_q    <= 1'b0;
                              end
                           end
                           `TSRP_PTR_UPPER: upper_q[15:8] <= byte_in;
                           `TSRP_PTR_LOWER: lower_q[15:8] <= byte_in;
                           default: ;
                        endcase
                     end
                     if (cnt_q == `TSRP_WORD_LAST)
                     begin
                        phase_q <= PH_CMD;
                        cnt_q   <= 5'h00;
                        if (ptr_ok(ptr_q))
                        begin
                           case (ptr_q[2:0])
                              `TSRP_PTR_CTRL:
                              begin
                                 res_q <= byte_in[`TSRP_CS_RES_HI:`TSRP_CS_RES_LO];
                                 rsv_q <= byte_in[`TSRP_CS_RSV_HI:`TSRP_CS_RSV_LO];
                              end
                              `TSRP_PTR_UPPER: upper_q[7:0] <= byte_in;
                              `TSRP_PTR_LOWER: lower_q[7:0] <= byte_in;
                              default: ;
                           endcase
                        end
                     end
                  end
                  default: phase_q <= PH_TEMP;
               endcase
            end
         end

         // Power-down waits for an idle converter; once down it stays down
         // through a single conversion until the host clears the bit
         shut_q <= pdown_q & (shut_q | ~conv_busy_i);

         // Completion updates the result last so it beats any clear
         if (conv_done_i)
         begin
            temp_q  <= conv_result_i;
            valid_q <= 1'b1;
            new_q   <= 1'b1;
            dav_q   <= 1'b1;
            pend_q  <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign sio_o                  = out_q[15];
   assign sio_oe_n_o             = oe_n_q;
   assign conv_run_o             = ~pdown_q;
   assign conv_single_o          = single_q;
   assign resolution_o           = res_q;
   assign power_down_o           = shut_q;
   assign data_valid_o           = valid_q;
   assign conversion_done_flag_o = dav_q;

endmodule
`default_nettype wire

// ---- logic/tsrp_pin_sync.v ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module tsrp_pin_sync
#(
   parameter RST_VAL = 1'b0
)
(
   input  wire clk_i,
   input  wire resetn_i,
   input  wire ce_i,
   input  wire pin_i,
   output wire level_o
);

   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg lvl_q;

   // The first stage feeds only the second; a change is taken once stages two and three agree
   always @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         s1_q  <= RST_VAL;
         s2_q  <= RST_VAL;
         s3_q  <= RST_VAL;
         lvl_q <= RST_VAL;
      end
      else if (ce_i)
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            lvl_q <= s3_q;
      end
   end

   assign level_o = lvl_q;

endmodule
`default_nettype wire
